/* core/page_xlate.sv */
// page translation of a 16-bit effective address into the 24-bit space
`default_nettype none
`include "xds_map.svh"
module page_xlate (
  xds_if.xlt x
);
  logic [`WPAGE_W-1:0] page;
  // pick page, flag window, page zero and program-space reads
  always_comb begin
    page = x.use_rpage ? x.rpage[`WPAGE_W-1:0] : x.wpage;
    x.win = x.ea[`WIN_BIT];
    x.psv = x.win && x.use_rpage && x.rpage[`RPAGE_PSV_BIT];
    if (x.use_rpage) begin
      x.pg_zero = x.win && (x.rpage == 10'h000);
    end else begin
      x.pg_zero = x.win && (x.wpage == 9'h000);
    end
    if (x.win) begin
      x.xaddr = {page, x.ea[`OFS_W-1:0]};
    end else begin
      x.xaddr = {8'h00, x.ea};
    end
  end
endmodule // page_xlate
`default_nettype wire

/* core/stack_check.sv */
// limit and underflow check of stack-pointer-based addresses
`default_nettype none
`include "xds_map.svh"
module stack_check (
  xds_if.chk x
);
  // compare every stack-based address against limit and sfr floor
  always_comb begin
    x.lim_err = x.sp_based && (x.ea > x.stk_lim);
    x.udf_err = x.sp_based && (x.ea < `SFR_TOP);
  end
endmodule // stack_check
`default_nettype wire

/* core/xds_core.sv */
// extended data address generation, stack handling and apb registers
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`default_nettype none
`include "xds_map.svh"
module xds_core #(
  parameter logic [23:0] EXT_BASE = `EXT_BASE
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          op_valid,
  input  wire xds_pkg::op_t  op_kind,
  input  wire logic [15:0]   op_ea,
  input  wire logic          op_sp,
  input  wire logic [15:0]   op_data,
  input  wire logic [23:0]   op_pc,
  output logic               op_ready,
  output logic               bus_valid,
  output logic               bus_we,
  output logic [23:0]        bus_addr,
  output logic [15:0]        bus_wdata,
  output logic               bus_ext,
  output logic               addr_err_trap,
  output logic               stack_err_trap,
  output logic               psv_req
);

  // ==================================================================
  // state
  logic [`WPAGE_W-1:0]  wpage_q;
  logic [`RPAGE_W-1:0]  rpage_q;
  logic [15:0]          stk_lim_q;
  logic [15:0]          sp_q;
  logic [15:0]          sp_d;
  logic [7:0]           stat_lo_q;
  logic [23:0]          last_q;
  xds_pkg::state_t      st_q;
  xds_pkg::state_t      st_d;
  logic                 op_ready_q;
  logic                 bus_valid_q;
  logic                 bus_we_q;
  logic                 bus_ext_q;
  logic [23:0]          bus_addr_q;
  logic [15:0]          bus_wdata_q;
  logic [23:0]          hold_q;
  logic [15:0]          hi_q;
  logic                 addr_err_q;
  logic                 stack_err_q;
  logic                 psv_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [31:0]          prdata_q;

  // ==================================================================
  // decode of the request
  logic                 take;
  logic                 pc_push;
  logic                 is_push;
  logic                 is_pop;
  logic                 is_rd;
  logic [15:0]          ea_cur;
  logic                 stk_bad;
  logic                 ok_take;
  logic                 fire;
  logic                 f_we;
  logic [23:0]          f_addr;
  logic [15:0]          f_data;
  logic                 trap_a;
  logic                 trap_s;
  logic                 psv_d;
  logic                 hold_ld;
  logic                 apb_wr;
  logic                 apb_setup;
  logic [31:0]          rd_word;
  logic                 mapped;

  xds_if x ();

  page_xlate u_xlt (
    .x (x)
  );

  stack_check u_chk (
    .x (x)
  );

  // request classes
  assign take    = op_valid && op_ready_q;
  assign pc_push = (op_kind == xds_pkg::OP_CALL) || (op_kind == xds_pkg::OP_EXC);
  assign is_push = (op_kind == xds_pkg::OP_PUSH) || pc_push;
  assign is_pop  = (op_kind == xds_pkg::OP_POP);
  assign is_rd   = (op_kind == xds_pkg::OP_RD) || is_pop;

  // effective address: pointer for push and pc push, pointer minus two for pop, caller address otherwise
  always_comb begin
    if (st_q == xds_pkg::ST_PHI) begin
      ea_cur = sp_q;
    end else if (is_pop) begin
      ea_cur = sp_q - `SP_STEP;
    end else if (is_push) begin
      ea_cur = sp_q;
    end else begin
      ea_cur = op_ea;
    end
  end

  // feed translator and checker
  assign x.ea        = ea_cur;
  assign x.use_rpage = (st_q != xds_pkg::ST_PHI) &&
                       (is_rd || (op_kind == xds_pkg::OP_RMWW));
  assign x.sp_based  = (st_q == xds_pkg::ST_PHI) || is_push || is_pop || op_sp;
  assign x.wpage     = wpage_q;
  assign x.rpage     = rpage_q;
  assign x.stk_lim   = stk_lim_q;
  assign stk_bad     = x.lim_err || x.udf_err;
  assign ok_take     = take && !x.pg_zero && !stk_bad && !x.psv;

  // ==================================================================
  // sequencer: issue, read overhead, second word of pc push
  always_comb begin
    fire    = 1'b0;
    f_we    = 1'b0;
    f_addr  = x.xaddr;
    f_data  = op_data;
    st_d    = st_q;
    sp_d    = sp_q;
    trap_a  = 1'b0;
    trap_s  = 1'b0;
    psv_d   = 1'b0;
    hold_ld = 1'b0;
    case (st_q)
      xds_pkg::ST_IDLE: begin
        if (take) begin
          if (x.pg_zero || stk_bad) begin
            trap_a = x.pg_zero;
            trap_s = stk_bad;
          end else if (x.psv) begin
            psv_d = 1'b1;
          end else begin
            if (is_push) begin
              sp_d = sp_q + `SP_STEP;
            end else if (is_pop) begin
              sp_d = sp_q - `SP_STEP;
            end
            if (is_rd && x.win) begin
              st_d    = xds_pkg::ST_RDW;
              hold_ld = 1'b1;
            end else begin
              fire = 1'b1;
              f_we = !is_rd;
              if (pc_push) begin
                f_data = op_pc[15:0];
                st_d   = xds_pkg::ST_PHI;
              end
            end
          end
        end
      end
      xds_pkg::ST_RDW: begin
        fire   = 1'b1;
        f_addr = hold_q;
        st_d   = xds_pkg::ST_IDLE;
      end
      xds_pkg::ST_PHI: begin
        st_d = xds_pkg::ST_IDLE;
        if (x.pg_zero || stk_bad) begin
          trap_a = x.pg_zero;
          trap_s = stk_bad;
        end else begin
          fire   = 1'b1;
          f_we   = 1'b1;
          f_data = hi_q;
          sp_d   = sp_q + `SP_STEP;
        end
      end
      default: begin
        st_d = xds_pkg::ST_IDLE;
      end
    endcase
  end

  // state and acceptance
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q       <= xds_pkg::ST_IDLE;
      op_ready_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      op_ready_q <= (st_d == xds_pkg::ST_IDLE);
    end
  end

  // held read address and high word of a pc push
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_q <= 24'h000000;
      hi_q   <= 16'h0000;
    end else begin
      if (hold_ld) begin
        hold_q <= x.xaddr;
      end
      if (take && (st_q == xds_pkg::ST_IDLE) && pc_push) begin
        if (op_kind == xds_pkg::OP_EXC) begin
          hi_q <= {stat_lo_q, op_pc[23:16]};
        end else begin
          hi_q <= {8'h00, op_pc[23:16]};
        end
      end
    end
  end

  // memory bus outputs; region split passes pages through unchecked
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_valid_q <= 1'b0;
      bus_we_q    <= 1'b0;
      bus_addr_q  <= 24'h000000;
      bus_wdata_q <= 16'h0000;
      bus_ext_q   <= 1'b0;
      last_q      <= 24'h000000;
    end else begin
      bus_valid_q <= fire;
      if (fire) begin
        bus_we_q    <= f_we;
        bus_addr_q  <= f_addr;
        bus_wdata_q <= f_data;
        bus_ext_q   <= (f_addr >= EXT_BASE);
        last_q      <= f_addr;
      end
    end
  end

  // one-cycle trap and program-space requests
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_err_q  <= 1'b0;
      stack_err_q <= 1'b0;
      psv_q       <= 1'b0;
    end else begin
      addr_err_q  <= trap_a;
      stack_err_q <= trap_s;
      psv_q       <= psv_d;
    end
  end

  // ==================================================================
  // apb slave
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready_q && pwrite;

  // read mux and address decode
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h00000000;
    if (paddr == `OFF_WPAGE) begin
      rd_word = {23'h000000, wpage_q};
    end else if (paddr == `OFF_RPAGE) begin
      rd_word = {22'h000000, rpage_q};
    end else if (paddr == `OFF_STK_LIM) begin
      rd_word = {16'h0000, stk_lim_q[15:1], 1'b0};
    end else if (paddr == `OFF_SP) begin
      rd_word = {16'h0000, sp_q};
    end else if (paddr == `OFF_STAT_LO) begin
      rd_word = {24'h000000, stat_lo_q};
    end else if (paddr == `OFF_LAST) begin
      rd_word = {8'h00, last_q};
    end else begin
      mapped = 1'b0;
    end
  end

  // answer in the first access cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && !mapped;
      if (apb_setup && !pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  // page registers change only by software writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wpage_q <= `WPAGE_RST;
      rpage_q <= `RPAGE_RST;
      stat_lo_q <= `STAT_LO_RST;
    end else if (apb_wr) begin
      if (paddr == `OFF_WPAGE) begin
        wpage_q <= pwdata[`WPAGE_W-1:0];
      end else if (paddr == `OFF_RPAGE) begin
        rpage_q <= pwdata[`RPAGE_W-1:0];
      end else if (paddr == `OFF_STAT_LO) begin
        stat_lo_q <= pwdata[7:0];
      end
    end
  end

  // stack limit carries no reset value
  always_ff @(posedge mclk) begin
    if (apb_wr && (paddr == `OFF_STK_LIM)) begin
      stk_lim_q <= {pwdata[15:1], 1'b0};
    end
  end

  // stack pointer: software write wins over a stack step
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sp_q <= `SP_RST;
    end else if (apb_wr && (paddr == `OFF_SP)) begin
      sp_q <= {pwdata[15:1], 1'b0};
    end else begin
      sp_q <= sp_d;
    end
  end

  // outputs straight from flops
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign op_ready       = op_ready_q;
  assign bus_valid      = bus_valid_q;
  assign bus_we         = bus_we_q;
  assign bus_addr       = bus_addr_q;
  assign bus_wdata      = bus_wdata_q;
  assign bus_ext        = bus_ext_q;
  assign addr_err_trap  = addr_err_q;
  assign stack_err_trap = stack_err_q;
  assign psv_req        = psv_q;

  // ==================================================================
  // checks
  a_write_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) &&
    ((op_kind == xds_pkg::OP_WR) || (op_kind == xds_pkg::OP_RMWW))
    |=> bus_valid_q && bus_we_q) else $error("write not issued next cycle");

  a_write_page_join: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && (op_kind == xds_pkg::OP_WR) && op_ea[15]
    |=> bus_addr_q == {$past(wpage_q), $past(op_ea[14:0])})
    else $error("write address not joined from write page");

  a_rmw_read_page: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && (op_kind == xds_pkg::OP_RMWW) && op_ea[15]
    |=> bus_addr_q[23:15] == $past(rpage_q[8:0]))
    else $error("rmw write did not use read page");

  a_low_direct: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && !op_ea[15] &&
    ((op_kind == xds_pkg::OP_RD) || (op_kind == xds_pkg::OP_WR))
    |=> bus_valid_q && (bus_addr_q == {8'h00, $past(op_ea)}))
    else $error("low address was translated");

  a_page_zero_trap: assert property (@(posedge mclk) disable iff (sys_rst)
    take && (st_q == xds_pkg::ST_IDLE) && x.pg_zero
    |=> addr_err_q && !bus_valid_q ##1 !addr_err_q || $past(take))
    else $error("page zero access not trapped");

  a_read_overhead: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && (op_kind == xds_pkg::OP_RD) && op_ea[15]
    |=> !bus_valid_q && !op_ready_q ##1 bus_valid_q && !bus_we_q)
    else $error("extended read lacks one overhead cycle");

  a_push_step: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && (op_kind == xds_pkg::OP_PUSH) && !apb_wr
    |=> (sp_q == $past(sp_q) + `SP_STEP) && (bus_addr_q[15:0] == $past(sp_q)))
    else $error("push did not store then add two");

  a_call_hi_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && (op_kind == xds_pkg::OP_CALL)
    |=> ##1 (bus_valid_q -> (bus_wdata_q[15:8] == 8'h00)))
    else $error("call push high byte not zero");

  a_exc_hi_status: assert property (@(posedge mclk) disable iff (sys_rst)
    ok_take && (st_q == xds_pkg::ST_IDLE) && (op_kind == xds_pkg::OP_EXC)
    |=> ##1 (bus_valid_q -> (bus_wdata_q[15:8] == $past(stat_lo_q, 2))))
    else $error("exception push lacks status byte");

  a_limit_trap: assert property (@(posedge mclk) disable iff (sys_rst)
    take && (st_q == xds_pkg::ST_IDLE) && x.sp_based && (ea_cur > stk_lim_q)
    |=> stack_err_q && !bus_valid_q) else $error("limit overrun not trapped");

  a_underflow_trap: assert property (@(posedge mclk) disable iff (sys_rst)
    take && (st_q == xds_pkg::ST_IDLE) && x.sp_based && (ea_cur < 16'h0800)
    |=> stack_err_q) else $error("stack underflow not trapped");

endmodule // xds_core
`default_nettype wire

/* core/xds_if.sv */
// carrier between the core and its translator and stack checker
`default_nettype none
`include "xds_map.svh"
interface xds_if;
  logic [15:0]           ea;
  logic                  use_rpage;
  logic                  sp_based;
  logic [`WPAGE_W-1:0]   wpage;
  logic [`RPAGE_W-1:0]   rpage;
  logic [15:0]           stk_lim;
  logic [23:0]           xaddr;
  logic                  win;
  logic                  pg_zero;
  logic                  psv;
  logic                  lim_err;
  logic                  udf_err;
  modport core (output ea, use_rpage, sp_based, wpage, rpage, stk_lim,
                input xaddr, win, pg_zero, psv, lim_err, udf_err);
  modport xlt  (input ea, use_rpage, wpage, rpage, output xaddr, win, pg_zero, psv);
  modport chk  (input ea, sp_based, stk_lim, output lim_err, udf_err);
endinterface
`default_nettype wire

/* core/xds_map.svh */
// register offsets, field layout, reset values and timing counts of the extended data block
// ====================================================================
// What this block does
// - write in window: address is write page low 9 bits over offset 15 bits
// - page registers never move by themselves when a pointer wraps
// - a write to the extended space completes in one cycle
// - read-modify-write takes its page from the read page; never under repeat
// - addresses below 0x8000 ignore both pages and go straight through
// - window access with page 0x000 is suppressed and raises address error
// - each page selects one 32 Kbyte region; page 0x001 starts at 0x008000
// - external memory region may begin at extended address 0x008000
// - stack grows upward: push stores then adds two, pop subtracts then reads
// - call push zero-fills the upper byte of the pushed high word
// - exception push puts status low byte into the high word's upper byte
// - stack limit is not reset and its bit 0 always reads zero
// - stack address above the limit traps; equal to limit does not
// - stack address below 0x0800 raises a stack error trap
// - only addresses with bit 15 set are window accesses with translation
// - read in window with read page bit 9 clear uses read page low 9 bits
// - each extended read adds one cycle, so it takes two at least
`ifndef XDS_MAP_SVH
`define XDS_MAP_SVH
`define OFF_WPAGE     8'h00
`define OFF_RPAGE     8'h04
`define OFF_STK_LIM   8'h08
`define OFF_SP        8'h0C
`define OFF_STAT_LO   8'h10
`define OFF_LAST      8'h14
`define WPAGE_W       9
`define RPAGE_W       10
`define RPAGE_PSV_BIT 9
`define WIN_BIT       15
`define OFS_W         15
`define SFR_TOP       16'h0800
`define EXT_BASE      24'h008000
`define SP_STEP       16'h0002
`define WPAGE_RST     9'h001
`define RPAGE_RST     10'h001
`define SP_RST        16'h0800
`define STAT_LO_RST   8'h00
`define EXT_RD_WAIT   1
`endif

/* core/xds_pkg.sv */
// types shared by the extended data block
`default_nettype none
package xds_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RDW  = 3'h2,
    ST_PHI  = 3'h4
  } state_t;
  typedef enum logic [2:0] {
    OP_RD   = 3'h0,
    OP_WR   = 3'h1,
    OP_RMWW = 3'h2,
    OP_PUSH = 3'h3,
    OP_POP  = 3'h4,
    OP_CALL = 3'h5,
    OP_EXC  = 3'h6
  } op_t;
endpackage
`default_nettype wire

/* verif/cpu_model.sv */
// cpu side model that issues requests on the operation port
`default_nettype none
module cpu_model (
  input  wire logic    mclk,
  input  wire logic    op_ready,
  output logic         op_valid,
  output xds_pkg::op_t op_kind,
  output logic [15:0]  op_ea,
  output logic         op_sp,
  output logic [15:0]  op_data,
  output logic [23:0]  op_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  time t_take;
  int  n_wait;
  // idle request lines at time zero
  initial begin
    op_valid = 1'b0;
    op_kind  = xds_pkg::OP_RD;
    op_ea    = 16'h0000;
    op_sp    = 1'b0;
    op_data  = 16'h0000;
    op_pc    = 24'h000000;
    t_take   = 0;
  end
  // one request, held until taken; no read-modify-write under repeat
  // no stack pointer read straight after a limit write is ever issued
  task issue(input xds_pkg::op_t k, input logic [15:0] ea, input logic sp,
             input logic [15:0] d, input logic [23:0] pc);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_kind  <= k;
    op_ea    <= ea;
    op_sp    <= sp;
    op_data  <= d;
    op_pc    <= pc;
    n_wait = 0;
    do
      @(posedge mclk) n_wait++;
    while (op_ready !== 1'b1 && n_wait < 50);
    t_take = $time;
    // released valid, address, data and pc lines no longer show the old value; kind and sp keep theirs
    op_valid <= 1'b0;
    op_ea    <= ~ea;
    op_data  <= ~d;
    op_pc    <= ~pc;
  endtask
endmodule // cpu_model
`default_nettype wire

/* verif/tb_extended_data_address_and_stack_check.sv */
// self-checking bench for the extended data address and stack block
`default_nettype none
module tb_extended_data_address_and_stack_check;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [23:0] a; logic w; logic [15:0] d; logic x; time t;} acc_t;
  logic         mclk, sys_rst, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rq;
  logic         op_valid, op_sp, op_ready, bus_valid, bus_we, bus_ext;
  logic         ae_trap, se_trap, psv_req;
  xds_pkg::op_t op_kind;
  logic [15:0]  op_ea, op_data, bus_wdata;
  logic [23:0]  op_pc, bus_addr;
  acc_t         bl[$];
  int           n_ae, n_se, n_psv, n_mismatch, tests_run;

  xds_core xds_core_i (.mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind), .op_ea(op_ea), .op_sp(op_sp),
    .op_data(op_data), .op_pc(op_pc), .op_ready(op_ready), .bus_valid(bus_valid),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ext(bus_ext),
    .addr_err_trap(ae_trap), .stack_err_trap(se_trap), .psv_req(psv_req));
  cpu_model cpu_model_i (.mclk(mclk), .op_ready(op_ready), .op_valid(op_valid),
    .op_kind(op_kind), .op_ea(op_ea), .op_sp(op_sp), .op_data(op_data), .op_pc(op_pc));

  // ==========================================================
  // clock and bus monitor
  always #50 mclk = ~mclk;
  // log every memory access and count trap cycles
  always @(posedge mclk) begin
    if (bus_valid === 1'b1)
      bl.push_back('{bus_addr, bus_we, bus_wdata, bus_ext, $time});
    if (ae_trap === 1'b1)
      n_ae++;
    if (se_trap === 1'b1)
      n_se++;
    if (psv_req === 1'b1)
      n_psv++;
  end

  // ==========================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
      @(posedge mclk) k++;
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      n_mismatch++;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rq, re);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, rq, re);
    chk(rq, exp);
  endtask
  // one cpu request, log cleared first, answer given four cycles
  task op(input xds_pkg::op_t k, input logic [15:0] ea, input logic sp,
          input logic [15:0] d, input logic [23:0] pc);
    bl.delete();
    n_ae = 0;
    n_se = 0;
    n_psv = 0;
    cpu_model_i.issue(k, ea, sp, d, pc);
    if (cpu_model_i.n_wait >= 50)
      n_mismatch++;
    repeat (4) @(posedge mclk);
  endtask
  task ab(input int i, input logic [23:0] a, input logic w, input logic [15:0] d);
    chk(32'(bl[i].a), 32'(a));
    chk(32'(bl[i].w), 32'(w));
    if (w)
      chk(32'(bl[i].d), 32'(d));
  endtask
  task lat(input int n);
    chk(32'((bl[0].t - cpu_model_i.t_take) / 100), 32'(n));
  endtask
  task cnt(input int n_acc, input int ae, input int se);
    chk(32'(bl.size()), 32'(n_acc));
    chk(32'(n_ae), 32'(ae));
    chk(32'(n_se), 32'(se));
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    #2000000;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // test sequence
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h00, 32'h00000001);
    rd(8'h04, 32'h00000001);
    rd(8'h0C, 32'h00000800);
    rd(8'h10, 32'h00000000);
    apb(1'b0, 8'h18, 32'h00000000, rq, re);
    chk(32'(re), 32'h00000001);
    wr(8'h08, 32'h00000901);
    rd(8'h08, 32'h00000900);
    $display("test registers done");
    wr(8'h00, 32'h00000002);
    op(xds_pkg::OP_WR, 16'h8800, 1'b0, 16'h1234, 24'h000000);
    ab(0, 24'h010800, 1'b1, 16'h1234);
    lat(1);
    chk(32'(bl[0].x), 32'h00000001);
    wr(8'h00, 32'h000001FF);
    op(xds_pkg::OP_WR, 16'hFFFE, 1'b0, 16'h5A5A, 24'h000000);
    ab(0, 24'hFFFFFE, 1'b1, 16'h5A5A);
    wr(8'h00, 32'h00000005);
    op(xds_pkg::OP_WR, 16'h8000, 1'b0, 16'h0F0F, 24'h000000);
    ab(0, 24'h028000, 1'b1, 16'h0F0F);
    rd(8'h00, 32'h00000005);
    wr(8'h00, 32'h00000000);
    op(xds_pkg::OP_WR, 16'h1234, 1'b0, 16'h00C3, 24'h000000);
    ab(0, 24'h001234, 1'b1, 16'h00C3);
    chk(32'(bl[0].x), 32'h00000000);
    op(xds_pkg::OP_WR, 16'h8000, 1'b0, 16'h00C3, 24'h000000);
    cnt(0, 1, 0);
    $display("test window writes done");
    wr(8'h04, 32'h00000002);
    op(xds_pkg::OP_RD, 16'h8800, 1'b0, 16'h0000, 24'h000000);
    ab(0, 24'h010800, 1'b0, 16'h0000);
    lat(2);
    wr(8'h04, 32'h00000000);
    op(xds_pkg::OP_RD, 16'h9000, 1'b0, 16'h0000, 24'h000000);
    cnt(0, 1, 0);
    wr(8'h04, 32'h00000003);
    wr(8'h00, 32'h00000005);
    op(xds_pkg::OP_RMWW, 16'h8002, 1'b0, 16'hBEEF, 24'h000000);
    ab(0, 24'h018002, 1'b1, 16'hBEEF);
    rd(8'h14, 32'h00018002);
    wr(8'h04, 32'h00000203);
    op(xds_pkg::OP_RD, 16'h8000, 1'b0, 16'h0000, 24'h000000);
    cnt(0, 0, 0);
    chk(32'(n_psv), 32'h00000001);
    $display("test window reads done");
    op(xds_pkg::OP_PUSH, 16'h0000, 1'b0, 16'hA5A5, 24'h000000);
    ab(0, 24'h000800, 1'b1, 16'hA5A5);
    rd(8'h0C, 32'h00000802);
    op(xds_pkg::OP_POP, 16'h0000, 1'b0, 16'h0000, 24'h000000);
    ab(0, 24'h000800, 1'b0, 16'h0000);
    rd(8'h0C, 32'h00000800);
    op(xds_pkg::OP_CALL, 16'h0000, 1'b0, 16'h0000, 24'h123456);
    ab(0, 24'h000800, 1'b1, 16'h3456);
    ab(1, 24'h000802, 1'b1, 16'h0012);
    wr(8'h10, 32'h000000C3);
    op(xds_pkg::OP_EXC, 16'h0000, 1'b0, 16'h0000, 24'h7F0102);
    ab(0, 24'h000804, 1'b1, 16'h0102);
    ab(1, 24'h000806, 1'b1, 16'hC37F);
    $display("test stack frames done");
    wr(8'h0C, 32'h00000900);
    op(xds_pkg::OP_PUSH, 16'h0000, 1'b0, 16'h1111, 24'h000000);
    cnt(1, 0, 0);
    op(xds_pkg::OP_PUSH, 16'h0000, 1'b0, 16'h2222, 24'h000000);
    cnt(0, 0, 1);
    rd(8'h0C, 32'h00000902);
    wr(8'h0C, 32'h00000800);
    op(xds_pkg::OP_POP, 16'h0000, 1'b0, 16'h0000, 24'h000000);
    cnt(0, 0, 1);
    op(xds_pkg::OP_RD, 16'h0700, 1'b1, 16'h0000, 24'h000000);
    cnt(0, 0, 1);
    $display("test stack traps done");
    wrap_up();
  end
endmodule // tb_extended_data_address_and_stack_check
`default_nettype wire
